// file: hdl/line_unit_irq_mask_bank.sv
/*
  Interrupt mask bank of one line channel: three mask registers,
  two edge-select registers, sticky status flags and the channel
  interrupt line, all behind a plain host register port.
  Flags clear by writing ones at their own index.
  Assumes status levels and one-cycle fault pulses come from the
  channel's detection logic on clk_sys, and host strobes are one
  cycle long and never high together.
*/
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/100ps
`include "irq_mask_bank_cfg.svh"

module line_unit_irq_mask_bank (
  input  wire logic                    clk_sys,
  input  wire logic                    rst,
  // Host register port
  input  wire irq_mask_pkg::host_req_t host_req,
  output logic      [7:0]              host_rdata,
  // Status levels
  input  wire logic                    line_signal_loss,
  input  wire logic                    system_signal_loss,
  input  wire logic                    tx_signal_loss,
  input  wire logic                    tx_clock_missing,
  input  wire logic                    driver_overcurrent,
  input  wire logic                    system_alarm_indication,
  input  wire logic                    line_alarm_indication,
  input  wire logic                    pattern_lock_state,
  input  wire logic                    inband_activate,
  input  wire logic                    inband_deactivate,
  // One-cycle fault events
  input  wire logic                    waveform_fault_evt,
  input  wire logic                    tx_jitter_fifo_evt,
  input  wire logic                    rx_jitter_fifo_evt,
  input  wire logic                    system_bipolar_evt,
  input  wire logic                    line_bipolar_evt,
  input  wire logic                    system_zeros_evt,
  input  wire logic                    line_zeros_evt,
  input  wire logic                    pattern_bit_fault_evt,
  input  wire logic                    fault_counter_wrap_evt,
  // Channel interrupt, active high
  output logic                         irq
);

  // ==========================================================
  // State
  // Masks, edge selects, read data and irq in one struct;
  // flags and edge history live in the child modules.

  typedef struct packed {
    irq_mask_pkg::line_tx_bits_t    mask_line_tx;
    irq_mask_pkg::alarm_code_bits_t mask_alarm;
    irq_mask_pkg::violation_bits_t  mask_viol;
    logic [7:0]                     edge_line_tx;
    logic [7:0]                     edge_alarm;
    logic [7:0]                     rdata;
    logic                           irq;
  } bank_state_t;

  bank_state_t                    st_reg;
  bank_state_t                    st_next;

  // ==========================================================
  // Source, flag and pending vectors
  // Each vector has the layout of its mask register,
  // so flag, mask and pending bits line up.

  irq_mask_pkg::line_tx_bits_t    lvl_line_tx;
  irq_mask_pkg::alarm_code_bits_t lvl_alarm;

  irq_mask_pkg::line_tx_bits_t    set_line_tx;
  irq_mask_pkg::alarm_code_bits_t set_alarm;
  irq_mask_pkg::violation_bits_t  set_viol;

  irq_mask_pkg::line_tx_bits_t    flag_line_tx;
  irq_mask_pkg::alarm_code_bits_t flag_alarm;
  irq_mask_pkg::violation_bits_t  flag_viol;

  irq_mask_pkg::line_tx_bits_t    pend_line_tx;
  irq_mask_pkg::alarm_code_bits_t pend_alarm;
  irq_mask_pkg::violation_bits_t  pend_viol;

  // Per-byte arrays for the flag loop
  logic [`LVL_SRC_W-1:0]          edge_evt;
  logic [7:0]                     set_v   [3];
  logic [7:0]                     clr_v   [3];
  logic [7:0]                     flags_v [3];
  logic [7:0]                     valid_v [3];
  logic [3:0]                     flag_addr [3];

  // ==========================================================
  // Host decode
  // Strobe and index must both match; an index
  // without a strobe leaves every register alone.

  function automatic logic wr_hit(
    input irq_mask_pkg::host_req_t req,
    input logic [3:0]              idx
  );
    wr_hit = req.wr && (req.addr == idx);
  endfunction

  // ==========================================================
  // Raw levels, laid out like the mask registers
  // Pulse-only positions stay zero, so they never
  // reach the edge selector.

  always_comb begin
    lvl_line_tx                              = '0;
    lvl_line_tx.driver_overcurrent_mask      = driver_overcurrent;
    lvl_line_tx.tx_clock_missing_mask        = tx_clock_missing;
    lvl_line_tx.tx_signal_loss_mask          = tx_signal_loss;
    lvl_line_tx.system_signal_loss_mask      = system_signal_loss;
    lvl_line_tx.line_signal_loss_mask        = line_signal_loss;

    // Alarm and inband code levels
    lvl_alarm                                = '0;
    lvl_alarm.system_alarm_indication_mask   = system_alarm_indication;
    lvl_alarm.line_alarm_indication_mask     = line_alarm_indication;
    lvl_alarm.pattern_lock_mask              = pattern_lock_state;
    lvl_alarm.inband_activate_mask           = inband_activate;
    lvl_alarm.inband_deactivate_mask         = inband_deactivate;
  end

  // ==========================================================
  // Level sources through the edge selector
  // History clears on reset: a level high at release
  // counts as a rising edge and sets its flag.

  irq_edge_detect u_edge (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .lvl      ({lvl_alarm, lvl_line_tx}),
    .any_edge ({st_reg.edge_alarm, st_reg.edge_line_tx}),
    .evt      (edge_evt)
  );

  // ==========================================================
  // Set vectors: edge events and fault pulses
  // Pulses take the positions with no level behind
  // them; edge events fill the rest.

  always_comb begin
    set_line_tx                         = edge_evt[7:0];
    // Pulses over the unused level positions
    set_line_tx.waveform_fault_mask     = waveform_fault_evt;
    set_line_tx.tx_jitter_fifo_mask     = tx_jitter_fifo_evt;
    set_line_tx.rx_jitter_fifo_mask     = rx_jitter_fifo_evt;

    set_alarm                           = edge_evt[15:8];

    // Violation pulses only
    set_viol                            = '0;
    set_viol.system_bipolar_violation_mask = system_bipolar_evt;
    set_viol.line_bipolar_violation_mask   = line_bipolar_evt;
    set_viol.system_excess_zeros_mask      = system_zeros_evt;
    set_viol.line_excess_zeros_mask        = line_zeros_evt;
    set_viol.pattern_bit_fault_mask        = pattern_bit_fault_evt;
    set_viol.fault_counter_wrap_mask       = fault_counter_wrap_evt;
  end

  // ==========================================================
  // Sticky flags, one byte per mask register
  // A set in the clearing cycle wins, so a clear
  // during a repeating fault loses no event.

  assign set_v[0]     = set_line_tx;
  assign set_v[1]     = set_alarm;
  assign set_v[2]     = set_viol;
  assign valid_v[0]   = `BITS_LINE_TX;
  assign valid_v[1]   = `BITS_ALARM;
  assign valid_v[2]   = `BITS_VIOL;
  assign flag_addr[0] = `ADDR_FLAG_LINE_TX;
  assign flag_addr[1] = `ADDR_FLAG_ALARM;
  assign flag_addr[2] = `ADDR_FLAG_VIOL;

  for (genvar g = 0; g < 3; g++) begin : g_flag
    // Write-one-to-clear
    // Only its own flag index reaches the clear input
    assign clr_v[g] = wr_hit(host_req, flag_addr[g]) ? host_req.wdata : 8'h00;

    irq_flag_byte u_flag (
      .clk_sys (clk_sys),
      .rst     (rst),
      .valid   (valid_v[g]),
      .set     (set_v[g]),
      .clr     (clr_v[g]),
      .flags   (flags_v[g])
    );
  end

  // Flag bytes back in their mask layouts
  assign flag_line_tx = flags_v[0];
  assign flag_alarm   = flags_v[1];
  assign flag_viol    = flags_v[2];

  // ==========================================================
  // Mask gating: a 0 mask bit lets its flag through
  // Masking gates only the interrupt; the flag still
  // latches and stays readable.

  always_comb begin
    pend_line_tx = '0;
    pend_alarm   = '0;
    pend_viol    = '0;
    // Line and transmit sources
    pend_line_tx.waveform_fault_mask =
      flag_line_tx.waveform_fault_mask & ~st_reg.mask_line_tx.waveform_fault_mask;
    pend_line_tx.tx_jitter_fifo_mask =
      flag_line_tx.tx_jitter_fifo_mask & ~st_reg.mask_line_tx.tx_jitter_fifo_mask;
    pend_line_tx.rx_jitter_fifo_mask =
      flag_line_tx.rx_jitter_fifo_mask & ~st_reg.mask_line_tx.rx_jitter_fifo_mask;
    pend_line_tx.driver_overcurrent_mask = flag_line_tx.driver_overcurrent_mask &
      ~st_reg.mask_line_tx.driver_overcurrent_mask;
    pend_line_tx.tx_clock_missing_mask = flag_line_tx.tx_clock_missing_mask &
      ~st_reg.mask_line_tx.tx_clock_missing_mask;
    pend_line_tx.tx_signal_loss_mask =
      flag_line_tx.tx_signal_loss_mask & ~st_reg.mask_line_tx.tx_signal_loss_mask;
    pend_line_tx.system_signal_loss_mask = flag_line_tx.system_signal_loss_mask &
      ~st_reg.mask_line_tx.system_signal_loss_mask;
    pend_line_tx.line_signal_loss_mask = flag_line_tx.line_signal_loss_mask &
      ~st_reg.mask_line_tx.line_signal_loss_mask;

    // Alarm and inband code sources
    pend_alarm.system_alarm_indication_mask = flag_alarm.system_alarm_indication_mask &
      ~st_reg.mask_alarm.system_alarm_indication_mask;
    pend_alarm.line_alarm_indication_mask = flag_alarm.line_alarm_indication_mask &
      ~st_reg.mask_alarm.line_alarm_indication_mask;
    pend_alarm.pattern_lock_mask =
      flag_alarm.pattern_lock_mask & ~st_reg.mask_alarm.pattern_lock_mask;
    pend_alarm.inband_activate_mask =
      flag_alarm.inband_activate_mask & ~st_reg.mask_alarm.inband_activate_mask;
    pend_alarm.inband_deactivate_mask = flag_alarm.inband_deactivate_mask &
      ~st_reg.mask_alarm.inband_deactivate_mask;

    // Violation and counter sources
    pend_viol.system_bipolar_violation_mask = flag_viol.system_bipolar_violation_mask &
      ~st_reg.mask_viol.system_bipolar_violation_mask;
    pend_viol.line_bipolar_violation_mask = flag_viol.line_bipolar_violation_mask &
      ~st_reg.mask_viol.line_bipolar_violation_mask;
    pend_viol.system_excess_zeros_mask = flag_viol.system_excess_zeros_mask &
      ~st_reg.mask_viol.system_excess_zeros_mask;
    pend_viol.line_excess_zeros_mask = flag_viol.line_excess_zeros_mask &
      ~st_reg.mask_viol.line_excess_zeros_mask;
    pend_viol.pattern_bit_fault_mask = flag_viol.pattern_bit_fault_mask &
      ~st_reg.mask_viol.pattern_bit_fault_mask;
    pend_viol.fault_counter_wrap_mask = flag_viol.fault_counter_wrap_mask &
      ~st_reg.mask_viol.fault_counter_wrap_mask;
  end

  // ==========================================================
  // Register writes, read data and interrupt
  // Reserved bits are cut off on write, so they
  // read back as zero with no read mask.

  always_comb begin
    st_next = st_reg;

    // Mask writes
    if (wr_hit(host_req, `ADDR_MASK_LINE_TX)) begin
      st_next.mask_line_tx = host_req.wdata & `BITS_LINE_TX;
    end
    if (wr_hit(host_req, `ADDR_MASK_ALARM)) begin
      st_next.mask_alarm = host_req.wdata & `BITS_ALARM;
    end
    if (wr_hit(host_req, `ADDR_MASK_VIOL)) begin
      st_next.mask_viol = host_req.wdata & `BITS_VIOL;
    end

    // Edge selects, level sources only
    if (wr_hit(host_req, `ADDR_EDGE_LINE_TX)) begin
      st_next.edge_line_tx = host_req.wdata & `BITS_LVL_LINE_TX;
    end
    if (wr_hit(host_req, `ADDR_EDGE_ALARM)) begin
      st_next.edge_alarm = host_req.wdata & `BITS_ALARM;
    end

    // Read data stands only in the cycle after the strobe
    st_next.rdata = 8'h00;
    // Masks, edge selects, flags, then raw levels
    if (host_req.rd) begin
      case (host_req.addr)
        `ADDR_MASK_LINE_TX: begin
          st_next.rdata = st_reg.mask_line_tx;
        end
        `ADDR_MASK_ALARM: begin
          st_next.rdata = st_reg.mask_alarm;
        end
        `ADDR_MASK_VIOL: begin
          st_next.rdata = st_reg.mask_viol;
        end
        `ADDR_EDGE_LINE_TX: begin
          st_next.rdata = st_reg.edge_line_tx;
        end
        `ADDR_EDGE_ALARM: begin
          st_next.rdata = st_reg.edge_alarm;
        end
        `ADDR_FLAG_LINE_TX: begin
          st_next.rdata = flag_line_tx;
        end
        `ADDR_FLAG_ALARM: begin
          st_next.rdata = flag_alarm;
        end
        `ADDR_FLAG_VIOL: begin
          st_next.rdata = flag_viol;
        end
        `ADDR_LVL_LINE_TX: begin
          st_next.rdata = lvl_line_tx;
        end
        `ADDR_LVL_ALARM: begin
          st_next.rdata = lvl_alarm;
        end
        default: begin
          st_next.rdata = 8'h00;
        end
      endcase
    end

    // Registered, so irq never glitches on the pin
    st_next.irq = |{pend_line_tx, pend_alarm, pend_viol};
  end

  // ==========================================================
  // State register
  // Reset leaves every source masked and every
  // edge select on rising only.

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_reg.mask_line_tx <= `RST_MASK_LINE_TX;
      st_reg.mask_alarm   <= `RST_MASK_ALARM;
      st_reg.mask_viol    <= `RST_MASK_VIOL;
      st_reg.edge_line_tx <= `RST_EDGE;
      st_reg.edge_alarm   <= `RST_EDGE;
      st_reg.rdata        <= 8'h00;
      st_reg.irq          <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // Outputs, straight from flip-flops

  assign host_rdata = st_reg.rdata;
  assign irq        = st_reg.irq;

endmodule

// file: include/irq_mask_bank_cfg.svh
/*
  Offsets, reset values and write masks of the channel interrupt
  mask bank, with the list of what the block must do.
  Assumes it is included by the top module and the edge detector.
*/
// What this block does
// - Mask bit 7 of line/tx mask gates waveform fault; 1 masks, resets masked.
// - Mask bit 6 of line/tx mask gates tx jitter FIFO fault; resets masked.
// - Mask bit 5 of line/tx mask gates rx jitter FIFO fault; resets masked.
// - Mask bit 4 of line/tx mask gates driver overcurrent; resets masked.
// - Mask bit 3 of line/tx mask gates missing tx clock; resets masked.
// - Mask bit 2 of line/tx mask gates tx signal loss; resets masked.
// - Mask bit 1 of line/tx mask gates system signal loss.
// - Mask bit 0 of line/tx mask gates line signal loss; resets masked.
// - Mask bit 7 of alarm/code mask gates system alarm indication.
// - Mask bit 6 of alarm/code mask gates line alarm indication.
// - Mask bit 5 of alarm/code mask gates pattern lock; resets masked.
// - Mask bit 1 of alarm/code mask gates inband activate code.
// - Mask bit 0 of alarm/code mask gates inband deactivate code.
// - Mask bit 5 of violation mask gates system bipolar violation.
// - Mask bit 4 of violation mask gates line bipolar violation.
// - Mask bit 3 of violation mask gates system excess zeros.
// - Mask bit 2 of violation mask gates line excess zeros.
// - Mask bit 1 of violation mask gates pattern bit error.
// - Mask bit 0 of violation mask gates error counter overflow.
// - Status flag sets on rising edge, or any edge if edge-select bit is 1.
`ifndef IRQ_MASK_BANK_CFG_SVH
`define IRQ_MASK_BANK_CFG_SVH

// ==========================================================
// Register offsets
`define ADDR_MASK_LINE_TX   4'h0
`define ADDR_MASK_ALARM     4'h1
`define ADDR_MASK_VIOL      4'h2
`define ADDR_EDGE_LINE_TX   4'h3
`define ADDR_EDGE_ALARM     4'h4
`define ADDR_FLAG_LINE_TX   4'h5
`define ADDR_FLAG_ALARM     4'h6
`define ADDR_FLAG_VIOL      4'h7
`define ADDR_LVL_LINE_TX    4'h8
`define ADDR_LVL_ALARM      4'h9

// ==========================================================
// Reset values and implemented bits
`define RST_MASK_LINE_TX    8'hFF
`define RST_MASK_ALARM      8'hE3
`define RST_MASK_VIOL       8'h3F
`define RST_EDGE            8'h00
`define BITS_LINE_TX        8'hFF
`define BITS_ALARM          8'hE3
`define BITS_VIOL           8'h3F
`define BITS_LVL_LINE_TX    8'h1F
`define LVL_SRC_W           16

`endif

// file: include/irq_mask_pkg.sv
/*
  Types of the channel interrupt mask bank: host request and the
  bit layouts shared by mask, flag and source vectors.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package irq_mask_pkg;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } host_req_t;

  typedef struct packed {
    logic waveform_fault_mask;
    logic tx_jitter_fifo_mask;
    logic rx_jitter_fifo_mask;
    logic driver_overcurrent_mask;
    logic tx_clock_missing_mask;
    logic tx_signal_loss_mask;
    logic system_signal_loss_mask;
    logic line_signal_loss_mask;
  } line_tx_bits_t;

  typedef struct packed {
    logic       system_alarm_indication_mask;
    logic       line_alarm_indication_mask;
    logic       pattern_lock_mask;
    logic [2:0] unused;
    logic       inband_activate_mask;
    logic       inband_deactivate_mask;
  } alarm_code_bits_t;

  typedef struct packed {
    logic [1:0] unused;
    logic       system_bipolar_violation_mask;
    logic       line_bipolar_violation_mask;
    logic       system_excess_zeros_mask;
    logic       line_excess_zeros_mask;
    logic       pattern_bit_fault_mask;
    logic       fault_counter_wrap_mask;
  } violation_bits_t;

endpackage

// file: hdl/irq_edge_detect.sv
/*
  Turns status levels into one-cycle events on a rising edge,
  or on either edge where the edge-select bit is set.
  Assumes levels come from logic on clk_sys.
*/
`timescale 1ns/100ps
`include "irq_mask_bank_cfg.svh"

module irq_edge_detect (
  input  wire logic                    clk_sys,
  input  wire logic                    rst,
  input  wire logic [`LVL_SRC_W-1:0]   lvl,
  input  wire logic [`LVL_SRC_W-1:0]   any_edge,
  output logic      [`LVL_SRC_W-1:0]   evt
);

  typedef struct packed {
    logic [`LVL_SRC_W-1:0] prev;
    logic [`LVL_SRC_W-1:0] evt;
  } edge_state_t;

  edge_state_t           st_reg;
  edge_state_t           st_next;
  logic [`LVL_SRC_W-1:0] hit;

  for (genvar i = 0; i < `LVL_SRC_W; i++) begin : g_bit
    assign hit[i] = (lvl[i] & ~st_reg.prev[i]) |
                    (any_edge[i] & ~lvl[i] & st_reg.prev[i]);
  end

  always_comb begin
    st_next      = st_reg;
    st_next.prev = lvl;
    st_next.evt  = hit;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign evt = st_reg.evt;

endmodule

// file: hdl/irq_flag_byte.sv
/*
  One byte of sticky interrupt status flags, cleared by writing
  ones; a set in the clearing cycle wins.
  Assumes set and clear come from logic on clk_sys.
*/
`timescale 1ns/100ps

module irq_flag_byte (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [7:0]  valid,
  input  wire logic [7:0]  set,
  input  wire logic [7:0]  clr,
  output logic      [7:0]  flags
);

  typedef struct packed {
    logic [7:0] flags;
  } flag_state_t;

  flag_state_t st_reg;
  flag_state_t st_next;

  always_comb begin
    st_next       = st_reg;
    st_next.flags = ((st_reg.flags & ~clr) | set) & valid;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign flags = st_reg.flags;

endmodule

// file: bench/irq_bank_monitor.sv
/*
  Port checker of the channel interrupt mask bank.
  Assumes it is bound into line_unit_irq_mask_bank on clk_sys.
*/
`timescale 1ns/100ps

module irq_bank_monitor (
  input  wire logic                    clk_sys,
  input  wire logic                    rst,
  input  wire irq_mask_pkg::host_req_t host_req,
  input  wire logic [7:0]              host_rdata,
  input  wire logic                    waveform_fault_evt,
  input  wire logic                    line_signal_loss,
  input  wire logic                    irq
);
  logic [7:0] line_sh_reg;
  logic [7:0] alarm_sh_reg;
  logic [7:0] viol_sh_reg;
  logic       all_masked;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  // ==========================================================
  // Shadow of the three mask registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      line_sh_reg  <= 8'hFF;
      alarm_sh_reg <= 8'hE3;
      viol_sh_reg  <= 8'h3F;
    end else if (host_req.wr) begin
      if (host_req.addr == 4'h0) line_sh_reg <= host_req.wdata;
      if (host_req.addr == 4'h1) alarm_sh_reg <= host_req.wdata & 8'hE3;
      if (host_req.addr == 4'h2) viol_sh_reg <= host_req.wdata & 8'h3F;
    end
  end

  assign all_masked = (line_sh_reg == 8'hFF) && (alarm_sh_reg == 8'hE3)
                      && (viol_sh_reg == 8'h3F);

  // ==========================================================
  // Event to interrupt sequences
  sequence s_wave_open;
    waveform_fault_evt && !line_sh_reg[7] ##1 (!line_sh_reg[7] && !host_req.wr) [*2];
  endsequence

  sequence s_loss_open;
    $rose(line_signal_loss) && !line_sh_reg[0] ##1 (!line_sh_reg[0] && !host_req.wr) [*3];
  endsequence

  // ==========================================================
  // Assertions
  a_rdata_idle_zero: assert property (!host_req.rd |=> host_rdata == 8'h00)
    else $error("read data not zero outside read cycle");
  a_line_mask_read: assert property (host_req.rd && host_req.addr == 4'h0
    |=> host_rdata == $past(line_sh_reg)) else $error("line mask readback wrong");
  a_alarm_mask_read: assert property (host_req.rd && host_req.addr == 4'h1
    |=> host_rdata == $past(alarm_sh_reg)) else $error("alarm mask readback wrong");
  a_viol_mask_read: assert property (host_req.rd && host_req.addr == 4'h2
    |=> host_rdata == $past(viol_sh_reg)) else $error("violation mask readback wrong");
  a_unmapped_read_zero: assert property (host_req.rd && host_req.addr > 4'h9
    |=> host_rdata == 8'h00) else $error("unmapped read not zero");
  a_all_masked_quiet: assert property (all_masked [*3] |-> !irq)
    else $error("interrupt raised with every source masked");
  a_wave_event_irq: assert property (s_wave_open |-> ##[0:1] irq)
    else $error("unmasked waveform fault gave no interrupt");
  a_loss_rise_irq: assert property (s_loss_open |-> ##[0:1] irq)
    else $error("unmasked line loss rise gave no interrupt");
endmodule

bind line_unit_irq_mask_bank irq_bank_monitor mon (
  .clk_sys            (clk_sys),
  .rst                (rst),
  .host_req           (host_req),
  .host_rdata         (host_rdata),
  .waveform_fault_evt (waveform_fault_evt),
  .line_signal_loss   (line_signal_loss),
  .irq                (irq)
);

// file: bench/tb.sv
/*
  Self-checking bench of the channel interrupt mask bank.
  Assumes the design, its package and its header are compiled first.
*/
`timescale 1ns/100ps

`define CHECK_EQ(name, exp, got) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
      err_count++; \
      $display("ERROR %s expected %0h seen %0h", name, exp, got); \
    end \
  end

module tb;
  // Mask register in the high nibble, bit in the low nibble
  localparam logic [7:0] src_map [19] = '{8'h07, 8'h06, 8'h05, 8'h25, 8'h24, 8'h23,
    8'h22, 8'h21, 8'h20, 8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h17, 8'h16, 8'h15,
    8'h11, 8'h10};
  localparam logic [7:0] mask_full [3] = '{8'hFF, 8'hE3, 8'h3F};

  logic                    clk_sys;
  logic                    rst;
  irq_mask_pkg::host_req_t hreq;
  logic [7:0]              host_rdata;
  logic [8:0]              evt_v;
  logic [9:0]              lvl_v;
  logic                    irq;
  int                      err_count;
  int                      comparisons;

  line_unit_irq_mask_bank uut (
    .clk_sys (clk_sys), .rst (rst), .host_req (hreq), .host_rdata (host_rdata),
    .line_signal_loss (lvl_v[0]), .system_signal_loss (lvl_v[1]),
    .tx_signal_loss (lvl_v[2]), .tx_clock_missing (lvl_v[3]),
    .driver_overcurrent (lvl_v[4]), .system_alarm_indication (lvl_v[5]),
    .line_alarm_indication (lvl_v[6]), .pattern_lock_state (lvl_v[7]),
    .inband_activate (lvl_v[8]), .inband_deactivate (lvl_v[9]),
    .waveform_fault_evt (evt_v[0]), .tx_jitter_fifo_evt (evt_v[1]),
    .rx_jitter_fifo_evt (evt_v[2]), .system_bipolar_evt (evt_v[3]),
    .line_bipolar_evt (evt_v[4]), .system_zeros_evt (evt_v[5]),
    .line_zeros_evt (evt_v[6]), .pattern_bit_fault_evt (evt_v[7]),
    .fault_counter_wrap_evt (evt_v[8]), .irq (irq)
  );

  initial clk_sys = 1'b0;
  always #4 clk_sys = ~clk_sys;

  // ==========================================================
  // Host access and closing tasks
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    hreq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    hreq <= '0;
    @(posedge clk_sys);
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    hreq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    hreq <= '0;
    @(negedge clk_sys);
    `CHECK_EQ("host_rdata", exp, host_rdata)
    @(posedge clk_sys);
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ==========================================================
  // One source: fire, check flag and line, clear, release
  task automatic run_src(input int i, input logic open);
    logic [3:0] r;
    logic [7:0] bm;
    r  = src_map[i][7:4];
    bm = 8'h01 << src_map[i][2:0];
    if (open) wr_reg(r, 8'hFF ^ bm);
    if (open && i > 8) wr_reg(r + 4'h3, bm);
    if (i < 9) begin
      evt_v[i] <= 1'b1;
      @(posedge clk_sys);
      evt_v[i] <= 1'b0;
    end else begin
      lvl_v[i - 9] <= 1'b1;
    end
    repeat (5) @(posedge clk_sys);
    `CHECK_EQ("irq", open, irq)
    rd_chk(r + 4'h5, bm);
    wr_reg(r + 4'h5, bm);
    repeat (3) @(posedge clk_sys);
    `CHECK_EQ("irq after clear", 1'b0, irq)
    if (i > 8) begin
      lvl_v[i - 9] <= 1'b0;
      repeat (5) @(posedge clk_sys);
      rd_chk(r + 4'h5, open ? bm : 8'h00);
      wr_reg(r + 4'h5, bm);
    end
    if (open) wr_reg(r, 8'hFF);
    if (open && i > 8) wr_reg(r + 4'h3, 8'h00);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    hreq = '0;
    evt_v = '0;
    lvl_v = '0;
    err_count = 0;
    comparisons = 0;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd_chk(4'h0, 8'hFF);
    rd_chk(4'h1, 8'hE3);
    rd_chk(4'h2, 8'h3F);
    for (int r = 0; r < 3; r++) begin
      rd_chk(4'(r + 5), 8'h00);
      wr_reg(4'(r), 8'h00);
      rd_chk(4'(r), 8'h00);
      wr_reg(4'(r), 8'hFF);
      rd_chk(4'(r), mask_full[r]);
    end
    wr_reg(4'hF, 8'hA5);
    rd_chk(4'hF, 8'h00);
    for (int i = 0; i < 9; i++) begin
      run_src(i, 1'b1);
      run_src(i, 1'b0);
    end
    for (int i = 9; i < 19; i++) begin
      run_src(i, 1'b1);
      run_src(i, 1'b0);
    end
    conclude();
  end

  // Watchdog well beyond the expected run of under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    conclude();
  end
endmodule
